/* File: logic/bit_sync.sv */
// two flip-flop synchroniser for single-bit levels from another domain
`timescale 1ns/1ns
`default_nettype none
module bit_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // bit_sync
`default_nettype wire

/* File: logic/tx_line_output_select.sv */
// per-port transmit output stage: electrical pair, optical data, frame marker
`timescale 1ns/1ns
`default_nettype none
module tx_line_output_select (
  input wire logic clk_i,
  input wire logic nrst_i,
  // per-port transmit clocks from outside this domain
  input wire logic [txsel_pkg::NUM_PORTS-1:0] port_tx_clock_i,
  // per-port configuration bits
  input wire logic [txsel_pkg::NUM_PORTS-1:0] dual_rail_select_i,
  input wire logic [txsel_pkg::NUM_PORTS-1:0] tx_line_enable_i,
  input wire logic [txsel_pkg::NUM_PORTS-1:0] tx_tristate_i,
  input wire logic [txsel_pkg::NUM_PORTS-1:0] tx_output_polarity_i,
  input wire logic [txsel_pkg::NUM_PORTS-1:0] duty_full_i,
  input wire logic [txsel_pkg::NUM_PORTS-1:0] remote_loop_i,
  // per-port coded data from the transmit datapath
  input wire logic [txsel_pkg::NUM_PORTS-1:0] in_valid_i,
  output logic [txsel_pkg::NUM_PORTS-1:0] in_ready_o,
  input wire txsel_pkg::tx_word_t [txsel_pkg::NUM_PORTS-1:0] in_word_i,
  // electrical line pair, enables low while driven
  output logic [txsel_pkg::NUM_PORTS-1:0] line_out_a_o,
  output logic [txsel_pkg::NUM_PORTS-1:0] line_out_b_o,
  output logic [txsel_pkg::NUM_PORTS-1:0] line_out_oe_n_o,
  // optical single-rail data
  output logic [txsel_pkg::NUM_PORTS-1:0] optical_tx_data_o,
  output logic [txsel_pkg::NUM_PORTS-1:0] optical_tx_data_oe_n_o,
  // frame marker
  output logic [txsel_pkg::NUM_PORTS-1:0] tx_frame_marker_o,
  output logic [txsel_pkg::NUM_PORTS-1:0] tx_frame_marker_oe_n_o,
  // status: a bit was due but the buffer was empty
  output logic [txsel_pkg::NUM_PORTS-1:0] underrun_o
);
  import txsel_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // one independent lane per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic clk_s;
    logic clk_prev_q;
    logic rise;
    logic fall;
    logic optical_mode;
    logic line_active;
    logic line_drive;
    logic optical_drive;
    logic fifo_valid;
    logic pop;
    logic [WORD_W-1:0] fifo_data;
    tx_word_t head;
    tx_word_t next_word;
    tx_word_t cur_q;
    logic sym_q;
    logic [HALF_CNT_W-1:0] cnt_q;
    logic [HALF_CNT_W-1:0] half_len_q;
    logic pulse_cut;
    logic line_a_q;
    logic line_b_q;
    logic line_oe_n_q;
    logic opt_q;
    logic opt_oe_n_q;
    logic fm_q;
    logic fm_oe_n_q;
    logic underrun_q;

    bit_sync u_clk_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(port_tx_clock_i[p]),
      .sync_o(clk_s)
    );

    word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(in_valid_i[p]),
      .in_ready_o(in_ready_o[p]),
      .in_data_i(in_word_i[p]),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data)
    );

    //////////////////////////////////////////////////////////////////////////
    // edge detection and mode decode
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        clk_prev_q <= 1'b0;
      end else begin
        clk_prev_q <= clk_s;
      end
    end

    assign rise = clk_s & ~clk_prev_q;
    assign fall = ~clk_s & clk_prev_q;
    assign optical_mode = dual_rail_select_i[p] & ~tx_line_enable_i[p];
    assign line_active = ~dual_rail_select_i[p] & tx_line_enable_i[p];
    assign line_drive = line_active & ~tx_tristate_i[p];
    assign optical_drive = dual_rail_select_i[p] & ~tx_tristate_i[p];
    // the buffer drains only while some output consumes bits, so that
    // back-pressure reaches the datapath when the port is idle
    assign pop = rise & (optical_mode | line_active);
    assign head = tx_word_t'(fifo_data);
    assign next_word = fifo_valid ? head : IDLE_WORD;

    //////////////////////////////////////////////////////////////////////////
    // current bit, taken on the rising transmit clock edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cur_q <= IDLE_WORD;
        underrun_q <= 1'b0;
      end else if (pop) begin
        cur_q <= next_word;
        underrun_q <= ~fifo_valid;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // cmi half-bit symbols: first half on the rising, second on the falling
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        sym_q <= 1'b0;
      end else if (rise) begin
        sym_q <= next_word.cmi_first;
      end else if (fall) begin
        sym_q <= cur_q.cmi_second;
      end
    end

    // the half-bit length is learnt from the previous half period, so the
    // 50% pulse tracks the line rate without a rate setting
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_q <= '0;
        half_len_q <= RST_HALF_LEN;
      end else if (rise | fall) begin
        cnt_q <= '0;
        half_len_q <= cnt_q + 1'b1;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end

    assign pulse_cut = ~duty_full_i[p] & (cnt_q >= (half_len_q >> 1));

    //////////////////////////////////////////////////////////////////////////
    // optical data output
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        opt_q <= RST_LEVEL;
        opt_oe_n_q <= RST_OE_N;
      end else begin
        opt_q <= (optical_mode & sym_q & ~pulse_cut) ^ tx_output_polarity_i[p];
        opt_oe_n_q <= ~optical_drive;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // frame marker, changed only on rising transmit clock edges
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        fm_q <= RST_LEVEL;
      end else if (rise) begin
        // in remote loop there is no frame position to give, so stay low
        fm_q <= optical_mode & ~remote_loop_i[p] & fifo_valid & head.frame_start;
      end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        fm_oe_n_q <= RST_OE_N;
      end else begin
        fm_oe_n_q <= ~optical_drive;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // electrical line pair
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        line_a_q <= RST_LEVEL;
        line_b_q <= RST_LEVEL;
      end else if (!line_active) begin
        line_a_q <= RST_LEVEL;
        line_b_q <= RST_LEVEL;
      end else if (rise) begin
        line_a_q <= next_word.rail_pos;
        line_b_q <= next_word.rail_neg;
      end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        line_oe_n_q <= RST_OE_N;
      end else begin
        line_oe_n_q <= ~line_drive;
      end
    end

    assign line_out_a_o[p] = line_a_q;
    assign line_out_b_o[p] = line_b_q;
    assign line_out_oe_n_o[p] = line_oe_n_q;
    assign optical_tx_data_o[p] = opt_q;
    assign optical_tx_data_oe_n_o[p] = opt_oe_n_q;
    assign tx_frame_marker_o[p] = fm_q;
    assign tx_frame_marker_oe_n_o[p] = fm_oe_n_q;
    assign underrun_o[p] = underrun_q;
  end
endmodule // tx_line_output_select
`default_nettype wire

/* File: logic/txsel_pkg.sv */
// shared types and constants of the transmit line output select block
//
// Summary of operation
// - electrical pair carries data only without dual-rail select
// - electrical outputs high-z until enabled without dual-rail select, not tristated
// - optical data changes on both clock edges, duty selectable
// - optical data polarity set by polarity bit
// - optical mode is dual-rail select without line enable
// - optical output high-z until dual-rail select, not tristated
// - frame marker on first frame bit, optical only
// - frame marker updates on rising transmit clock edges
// - frame marker high-z until dual-rail select, not tristated
// - frame marker meaningless in remote loop configuration
package txsel_pkg;

  localparam int NUM_PORTS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int HALF_CNT_W = 8;

  // one transmitted bit as delivered by the internal datapath
  typedef struct packed {
    logic frame_start;
    logic cmi_first;
    logic cmi_second;
    logic rail_pos;
    logic rail_neg;
  } tx_word_t;

  localparam int WORD_W = $bits(tx_word_t);

  // sent when the buffer runs dry: a coded zero with no line pulse
  localparam tx_word_t IDLE_WORD = '{frame_start: 1'b0, cmi_first: 1'b0,
                                     cmi_second: 1'b1, rail_pos: 1'b0,
                                     rail_neg: 1'b0};

  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_LEVEL = 1'b0;
  localparam logic [HALF_CNT_W-1:0] RST_HALF_LEN = 8'hff;

endpackage : txsel_pkg

/* File: logic/word_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  // ready comes from a flop fed by the next count, so it matches a
  // count compare cycle for cycle without a comparator on the port
  assign in_ready_o = ready_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_comb begin
    case ({push, pop})
      2'b10: cnt_d = cnt_q + 1'b1;
      2'b01: cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != DEPTH_C);
    end
  end
endmodule // word_fifo
`default_nettype wire

/* File: tb/far_end_rx.sv */
// far-end receiver model: the level a fibre transmitter input sees on one pin
`timescale 1ns/1ns
`default_nettype none
module far_end_rx (
  input wire logic clk_i,
  input wire logic level_i,
  input wire logic oe_n_i,
  output logic pin_o
);
  logic last_q = 1'b0;
  always @(posedge clk_i) begin
    if (!oe_n_i) begin
      last_q <= level_i;
    end
  end
  // a released pin shows the inverse of its last level so stale data never matches
  assign pin_o = oe_n_i ? ~last_q : level_i;
endmodule // far_end_rx
`default_nettype wire

/* File: tb/tx_line_output_select_tb.sv */
// testbench for the per-port transmit output stage
`timescale 1ns/1ns
`default_nettype none
module tx_line_output_select_tb;
  import txsel_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pclk = 1'b0;
  logic opt_pin;
  logic [7:0] drs = '0, le = '0, ts = '0, pol = '0, duty = 8'hff, rl = '0, vld = '0;
  tx_word_t [7:0] wrd = '0;
  logic [7:0] in_ready_o, line_out_a_o, line_out_b_o, line_out_oe_n_o, underrun_o;
  logic [7:0] optical_tx_data_o, optical_tx_data_oe_n_o;
  logic [7:0] tx_frame_marker_o, tx_frame_marker_oe_n_o;
  wire logic [7:0] port_tx_clock_i = {8{pclk}};
  int err_total = 0;
  int compares = 0;
  tx_line_output_select DUT (.dual_rail_select_i(drs), .tx_line_enable_i(le),
    .tx_tristate_i(ts), .tx_output_polarity_i(pol), .duty_full_i(duty),
    .remote_loop_i(rl), .in_valid_i(vld), .in_word_i(wrd), .*);
  far_end_rx FE (.clk_i(clk_i), .level_i(optical_tx_data_o[0]),
    .oe_n_i(optical_tx_data_oe_n_o[0]), .pin_o(opt_pin));
  always #20 clk_i = ~clk_i;
  initial begin
    #7;
    forever #160 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic final_report;
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic push(input int p, input tx_word_t w);
    int n = 0;
    @(posedge clk_i);
    vld[p] <= 1'b1;
    wrd[p] <= w;
    #1;
    while (in_ready_o[p] !== 1'b1 && n < 200) begin
      tick;
      n++;
    end
    @(posedge clk_i);
    vld[p] <= 1'b0;
  endtask
  // length of the next stretch at level lv on the far-end optical pin
  task automatic run(input logic lv, input int e);
    int k = 0;
    int n = 0;
    while (opt_pin === lv && k < 40) begin
      tick;
      k++;
    end
    while (opt_pin !== lv && k < 80) begin
      tick;
      k++;
    end
    while (opt_pin === lv && n < 40) begin
      tick;
      n++;
    end
    chk("optical run", e[7:0], n[7:0]);
  endtask
  ////////////////////////////////////////
  task automatic t_oe;
    tick;
    chk("line oe", 8'hff, line_out_oe_n_o);
    chk("optical oe", 8'hff, optical_tx_data_oe_n_o);
    chk("marker oe", 8'hff, tx_frame_marker_oe_n_o);
    @(posedge clk_i);
    drs <= 8'h19;
    le <= 8'h16;
    ts <= 8'h0c;
    repeat (3) tick;
    chk("line oe", 8'hfd, line_out_oe_n_o);
    chk("optical oe", 8'hee, optical_tx_data_oe_n_o);
    chk("idle level", 8'h00, optical_tx_data_o[4]);
  endtask
  task automatic t_elec;
    int k = 0;
    push(1, 5'h02);
    while (line_out_a_o[1] !== 1'b1 && k < 80) begin
      tick;
      k++;
    end
    chk("line a", 8'h01, line_out_a_o[1]);
    chk("line b", 8'h00, line_out_b_o[1]);
    repeat (12) tick;
    chk("underrun", 8'h01, underrun_o[1]);
    chk("idle line a", 8'h00, line_out_a_o[1]);
  endtask
  task automatic t_opt;
    run(1'b1, 4);
    @(posedge clk_i);
    duty <= 8'h00;
    repeat (20) tick;
    run(1'b1, 2);
    @(posedge clk_i);
    duty <= 8'hff;
    pol <= 8'h01;
    repeat (20) tick;
    run(1'b0, 4);
    @(posedge clk_i);
    pol <= 8'h00;
  endtask
  task automatic t_mark;
    int k = 0;
    int n = 0;
    repeat (32) tick;
    push(0, 5'h14);
    while (tx_frame_marker_o[0] !== 1'b1 && k < 80) begin
      tick;
      k++;
    end
    while (tx_frame_marker_o[0] === 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk("marker width", 8'h08, n[7:0]);
    @(posedge clk_i);
    rl <= 8'h01;
    push(0, 5'h14);
    n = 0;
    repeat (40) begin
      tick;
      n += int'(tx_frame_marker_o[0] !== 1'b0);
    end
    chk("looped marker", 8'h00, n[7:0]);
    @(posedge clk_i);
    rl <= 8'h00;
  endtask
  // port 5 neither optical nor electrical: buffer fills, then drains in order
  task automatic t_fifo;
    int k = 0;
    int r = 0;
    logic pa = 1'b0;
    for (int i = 0; i < 8; i++) push(5, i[0] ? 5'h01 : 5'h02);
    tick;
    chk("full ready", 8'h00, in_ready_o[5]);
    @(posedge clk_i);
    le <= 8'h36;
    while (underrun_o[5] !== 1'b1 && k < 150) begin
      tick;
      k++;
      r += int'(line_out_a_o[5] === 1'b1 && pa !== 1'b1);
      pa = line_out_a_o[5];
    end
    chk("drained pulses", 8'h04, r[7:0]);
    chk("drained ready", 8'h01, in_ready_o[5]);
  endtask
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_oe();
    t_elec();
    t_opt();
    t_mark();
    t_fifo();
    final_report();
  end
endmodule // tx_line_output_select_tb
bind tx_line_output_select txsel_assertions CHK (.*);
`default_nettype wire

/* File: tb/txsel_assertions.sv */
// checker for mode, enable and timing relations of the transmit output stage
`timescale 1ns/1ns
`default_nettype none
module txsel_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] port_tx_clock_i,
  input wire logic [7:0] dual_rail_select_i,
  input wire logic [7:0] tx_line_enable_i,
  input wire logic [7:0] tx_tristate_i,
  input wire logic [7:0] tx_output_polarity_i,
  input wire logic [7:0] duty_full_i,
  input wire logic [7:0] remote_loop_i,
  input wire logic [7:0] line_out_a_o,
  input wire logic [7:0] line_out_b_o,
  input wire logic [7:0] line_out_oe_n_o,
  input wire logic [7:0] optical_tx_data_o,
  input wire logic [7:0] optical_tx_data_oe_n_o,
  input wire logic [7:0] tx_frame_marker_o,
  input wire logic [7:0] tx_frame_marker_oe_n_o,
  input wire logic [7:0] underrun_o
);
  logic [47:0] cfg_q;
  logic [4:0] calm_q;
  wire logic [47:0] cfg = {dual_rail_select_i, tx_line_enable_i, tx_tristate_i,
    tx_output_polarity_i, duty_full_i, remote_loop_i};
  // data only settles a bit period after a mode change, so wait for a calm stretch;
  // the edge that first sees a new setting still shows the old outputs
  wire logic calm = (calm_q == 5'h1f) && (cfg == cfg_q);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q <= '0;
      calm_q <= '0;
    end else begin
      cfg_q <= cfg;
      calm_q <= (cfg != cfg_q) ? 5'h00 : (calm ? calm_q : calm_q + 5'h01);
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  line_oe_a: assert property ($past(nrst_i) |-> line_out_oe_n_o ==
    ~(~$past(dual_rail_select_i) & $past(tx_line_enable_i) & ~$past(tx_tristate_i)))
    else $error("line enable wrong");
  opt_oe_a: assert property ($past(nrst_i) |-> optical_tx_data_oe_n_o ==
    ~($past(dual_rail_select_i) & ~$past(tx_tristate_i))) else $error("optical enable wrong");
  mark_oe_a: assert property (tx_frame_marker_oe_n_o == optical_tx_data_oe_n_o)
    else $error("marker enable wrong");
  mark_mode_a: assert property (calm |-> (tx_frame_marker_o & ~(dual_rail_select_i &
    ~tx_line_enable_i & ~remote_loop_i)) == 8'h00) else $error("marker outside mode");
  line_sel_a: assert property (calm |-> ((line_out_a_o | line_out_b_o) &
    dual_rail_select_i) == 8'h00) else $error("line data while optical");
  idle_word_a: assert property (((line_out_a_o | line_out_b_o | tx_frame_marker_o) &
    underrun_o) == 8'h00) else $error("idle bit not quiet");
  mark_edge_a: assert property (calm && $changed(tx_frame_marker_o[0]) |->
    $past(port_tx_clock_i[0], 3)) else $error("marker moved off rising edge");
  opt_edge_a: assert property (calm && duty_full_i[0] && $changed(optical_tx_data_o[0]) |->
    $past(port_tx_clock_i[0], 4) != $past(port_tx_clock_i[0], 7))
    else $error("optical moved off clock edge");
  pol_idle_a: assert property (calm |-> ((optical_tx_data_o ^ tx_output_polarity_i) &
    dual_rail_select_i & tx_line_enable_i) == 8'h00) else $error("idle level wrong");
endmodule // txsel_assertions
`default_nettype wire
